// ### hw/phc_core.sv
// PCM highway, serial control port and interrupt pins of a four-channel codec
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
// Functional notes
// - Control bytes move MSB first, one bit per shift-clock period.
// - Control data pin driven only while sending read data.
// - Companded: one byte per channel per frame in its slot, MSB first.
// - Linear: two consecutive bytes per channel per frame received.
// - Transmit 8-bit bursts, 16-bit for linear or signalling, on A/B/both.
// - Transmit outputs float outside slots, on cutoff, or when neither active nor signalling.
// - Frame sync marks time slot 0, clock slot 0.
// - Interrupt low when any unmasked real-time input bit changes.
// - Armed transmit-data interrupt also asserts the interrupt output.
// - Interrupt held until causing register read or any reset.
// - Interrupt driver selectable push-pull or open-drain.
// - Each real-time input bit has its own interrupt mask.
// - Detector mux select output usable when clocked from PCM clock.
// - Low on reset pin returns device to default state.
// - Slot-active open-drain outputs low exactly while highway driven.
// - Chip select low 16 shift edges resets device at release.
// - Host shift clock moves control data, at most 4.096 MHz.
module phc_core #(
  parameter int NCH = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // PCM highway pins
  input  wire logic        pcm_clk,
  input  wire logic        frame_sync,
  input  wire logic        pcm_rx_a,
  input  wire logic        pcm_rx_b,
  output logic             pcm_tx_a,
  output logic             pcm_tx_a_oe,
  output logic             pcm_tx_b,
  output logic             pcm_tx_b_oe,
  output logic             slot_active_a_n,
  output logic             slot_active_a_oe,
  output logic             slot_active_b_n,
  output logic             slot_active_b_oe,
  // Serial control port pins
  input  wire logic        ctl_shift_clock,
  input  wire logic        ctl_cs_n,
  input  wire logic        serial_ctl_data_in,
  output logic             serial_ctl_data_out,
  output logic             serial_ctl_data_oe,
  // Line inputs, reset pin, interrupt, mux select
  input  wire logic [7:0]  rtd_in,
  input  wire logic        reset_pin_n,
  output logic             int_n,
  output logic             int_oe,
  output logic             detector_mux_select,
  output logic             detector_mux_oe
);
  // ==========================================================
  // Pin synchronisers: three stages, change accepted when 2 and 3 agree
  logic [phc_pkg::SYNC_W-1:0] s1_r, s2_r, s3_r, pf_r;
  wire  [phc_pkg::SYNC_W-1:0] pins = {rtd_in, reset_pin_n, serial_ctl_data_in, ctl_cs_n,
                                      ctl_shift_clock, pcm_rx_b, pcm_rx_a, frame_sync, pcm_clk};
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= phc_pkg::SYNC_RST;
      s2_r <= phc_pkg::SYNC_RST;
      s3_r <= phc_pkg::SYNC_RST;
      pf_r <= phc_pkg::SYNC_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pf_r <= (s2_r & s3_r) | (pf_r & (s2_r | s3_r));
    end
  end
  wire       pclk_f = pf_r[0];
  wire       fs_f   = pf_r[1];
  wire       ctl_shift_clock_f = pf_r[4];
  wire       cs_n_f = pf_r[5];
  wire       din_f  = pf_r[6];
  wire       rpin_f = pf_r[7];
  wire [7:0] rtd_f  = pf_r[15:8];

  // ==========================================================
  // Edge detection and combined reset
  logic pclk_d_r, ctl_shift_clock_d_r, cs_d_r, cs_rst_r;
  wire  pcm_rise = pclk_f & ~pclk_d_r;
  wire  pcm_fall = ~pclk_f & pclk_d_r;
  wire  ctl_shift_clock_rise = ctl_shift_clock_f & ~ctl_shift_clock_d_r;
  wire  rst_all = rst | ~rpin_f | cs_rst_r;

  // ==========================================================
  // Registers and bus handshake
  logic [phc_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0]                slots_r;
  logic [7:0]                 mask_r, rtd_prev_r, rtd_pend_r, ctl_rx_r, ctl_tx_r;
  logic [63:0]                txd_r;
  logic [63:0]                rx_all;
  logic                       tx_pend_r, ctl_new_r;
  wire  wr_acc = write & ~waitrequest;
  wire  rd_acc = read & ~waitrequest;
  wire  wide_rx  = ctrl_r[phc_pkg::CB_LINEAR];
  wire  wide_tx  = ctrl_r[phc_pkg::CB_LINEAR] | ctrl_r[phc_pkg::CB_SIGNAL];
  wire  tx_ok    = ~ctrl_r[phc_pkg::CB_CUTOFF] &
                   (ctrl_r[phc_pkg::CB_ACTIVE] | ctrl_r[phc_pkg::CB_SIGNAL]);
  wire  [2:0] cslot = ctrl_r[phc_pkg::CB_CSLOT_LO +: 3];

  // Address decode and read selection
  wire  a_ctrl  = address == phc_pkg::OFS_CTRL;
  wire  a_slots = address == phc_pkg::OFS_SLOTS;
  wire  a_mask  = address == phc_pkg::OFS_MASK;
  wire  a_rtd   = address == phc_pkg::OFS_RTD;
  wire  a_stat  = address == phc_pkg::OFS_STATUS;
  wire  a_cbyte = address == phc_pkg::OFS_CTLBYTE;
  wire  a_tx    = address[7:4] == phc_pkg::OFS_TXDATA[7:4];
  wire  a_rx    = address[7:4] == phc_pkg::OFS_RXDATA[7:4];
  wire  [5:0] lane = {address[3:2], 4'h0};
  wire  [31:0] rd_mux =
    a_ctrl  ? {19'h0_0000, ctrl_r} :
    a_slots ? slots_r :
    a_mask  ? {24'h00_0000, mask_r} :
    a_rtd   ? {24'h00_0000, rtd_f} :
    a_stat  ? {22'h00_0000, ctl_new_r, tx_pend_r, rtd_pend_r} :
    a_cbyte ? {24'h00_0000, ctl_rx_r} :
    a_tx    ? {16'h0000, txd_r[lane +: 16]} :
    a_rx    ? {16'h0000, rx_all[lane +: 16]} : 32'h0000_0000;

  // Handshake: one wait cycle, then accept
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest)
        readdata <= rd_mux;
    end
  end

  // Software-written registers
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ctrl_r   <= phc_pkg::CTRL_RST;
      slots_r  <= phc_pkg::SLOTS_RST;
      mask_r   <= phc_pkg::MASK_RST;
      ctl_tx_r <= 8'h00;
      txd_r    <= 64'h0000_0000_0000_0000;
    end else if (wr_acc) begin
      if (a_ctrl)  ctrl_r   <= writedata[phc_pkg::CTRL_W-1:0];
      if (a_slots) slots_r  <= writedata;
      if (a_mask)  mask_r   <= writedata[7:0];
      if (a_cbyte) ctl_tx_r <= writedata[7:0];
      if (a_tx)    txd_r[lane +: 16] <= writedata[15:0];
    end
  end

  // ==========================================================
  // Frame position counter on PCM clock rising edge
  logic [phc_pkg::POS_W-1:0] pos_r;
  logic                      rise_d_r, frame_r;
  wire  [phc_pkg::POS_W-1:0] pos_eff = pos_r - {7'h00, cslot};
  always_ff @(posedge clk) begin
    if (rst_all) begin
      pos_r    <= 10'h000;
      rise_d_r <= 1'b0;
      frame_r  <= 1'b0;
    end else begin
      rise_d_r <= pcm_rise;
      frame_r  <= pcm_rise & fs_f;
      if (pcm_rise)
        pos_r <= fs_f ? 10'h000 : pos_r + 10'h001;
    end
  end

  // ==========================================================
  // Per-channel slot match, receive shift and transmit bit
  logic [NCH-1:0] tx_hit, tx_bit;
  wire  rx_bit = ctrl_r[phc_pkg::CB_RX_FROM_B] ? pf_r[3] : pf_r[2];
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] sh_r, rxd_r;
      wire  [6:0]  slot = slots_r[g*8 +: 7];
      wire         s0   = pos_eff[9:3] == slot;
      wire         s1   = pos_eff[9:3] == slot + 7'h01;
      wire  [3:0]  idx  = {s1, pos_eff[2:0]};
      wire         rx_hit = s0 | (wide_rx & s1);
      assign tx_hit[g] = s0 | (wide_tx & s1);
      assign tx_bit[g] = wide_tx ? txd_r[g*16 + 15 - idx] :
                                   txd_r[g*16 + 7 - pos_eff[2:0]];
      assign rx_all[g*16 +: 16] = rxd_r;
      // Receive MSB first on falling edge, snapshot at frame start
      always_ff @(posedge clk) begin
        if (rst_all) begin
          sh_r  <= 16'h0000;
          rxd_r <= 16'h0000;
        end else begin
          if (pcm_fall & rx_hit)
            sh_r <= {sh_r[14:0], rx_bit};
          if (frame_r)
            rxd_r <= sh_r;
        end
      end
    end
  endgenerate

  // Transmit outputs and slot-active strobes
  wire any_hit = |tx_hit;
  wire any_bit = |(tx_hit & tx_bit);
  wire drv_a   = any_hit & tx_ok & ctrl_r[phc_pkg::CB_TX_A_EN];
  wire drv_b   = any_hit & tx_ok & ctrl_r[phc_pkg::CB_TX_B_EN];
  always_ff @(posedge clk) begin
    if (rst_all) begin
      pcm_tx_a         <= 1'b0;
      pcm_tx_b         <= 1'b0;
      pcm_tx_a_oe      <= 1'b0;
      pcm_tx_b_oe      <= 1'b0;
      slot_active_a_n  <= 1'b0;
      slot_active_b_n  <= 1'b0;
      slot_active_a_oe <= 1'b0;
      slot_active_b_oe <= 1'b0;
    end else if (rise_d_r | ~tx_ok) begin
      pcm_tx_a         <= any_bit;
      pcm_tx_b         <= any_bit;
      pcm_tx_a_oe      <= drv_a;
      pcm_tx_b_oe      <= drv_b;
      slot_active_a_oe <= drv_a;
      slot_active_b_oe <= drv_b;
    end
  end

  // ==========================================================
  // Serial control port: command byte, then data byte in or out
  logic [4:0] cs_cnt_r;
  logic [2:0] bit_r;
  logic [7:0] ish_r, osh_r;
  logic       cmd_done_r, rd_mode_r;
  wire        byte_end = ctl_shift_clock_rise & ~cs_n_f & (bit_r == 3'h7);
  wire [7:0]  ish_nxt  = {ish_r[6:0], din_f};
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_shift_clock_d_r <= 1'b0;
      pclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      cs_rst_r <= 1'b0;
      cs_cnt_r <= 5'h00;
    end else begin
      ctl_shift_clock_d_r <= ctl_shift_clock_f;
      pclk_d_r <= pclk_f;
      cs_d_r   <= cs_n_f;
      cs_rst_r <= cs_n_f & ~cs_d_r & (cs_cnt_r >= phc_pkg::CS_RST_EDGES);
      if (cs_n_f)
        cs_cnt_r <= 5'h00;
      else if (ctl_shift_clock_rise & (cs_cnt_r < phc_pkg::CS_RST_EDGES))
        cs_cnt_r <= cs_cnt_r + 5'h01;
    end
  end

  // Shift logic; output only during the read data byte
  always_ff @(posedge clk) begin
    if (rst_all | cs_n_f) begin
      bit_r               <= 3'h0;
      ish_r               <= 8'h00;
      osh_r               <= 8'h00;
      cmd_done_r          <= 1'b0;
      rd_mode_r           <= 1'b0;
      serial_ctl_data_out <= 1'b0;
      serial_ctl_data_oe  <= 1'b0;
    end else if (ctl_shift_clock_rise) begin
      bit_r <= bit_r + 3'h1;
      ish_r <= ish_nxt;
      if (byte_end & ~cmd_done_r) begin
        cmd_done_r          <= 1'b1;
        rd_mode_r           <= ish_nxt[7];
        osh_r               <= {ctl_tx_r[6:0], 1'b0};
        serial_ctl_data_out <= ctl_tx_r[7];
        serial_ctl_data_oe  <= ish_nxt[7];
      end else if (byte_end) begin
        cmd_done_r          <= 1'b0;
        rd_mode_r           <= 1'b0;
        serial_ctl_data_oe  <= 1'b0;
      end else if (rd_mode_r) begin
        serial_ctl_data_out <= osh_r[7];
        osh_r               <= {osh_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Pending events; a new event wins over a read-clear
  wire rtd_ev  = |((rtd_f ^ rtd_prev_r) & ~mask_r);
  wire wbyte   = byte_end & cmd_done_r & ~rd_mode_r & ~cs_n_f;
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rtd_prev_r <= 8'h00;
      rtd_pend_r <= 8'h00;
      tx_pend_r  <= 1'b0;
      ctl_new_r  <= 1'b0;
      ctl_rx_r   <= 8'h00;
    end else begin
      rtd_prev_r <= rtd_f;
      rtd_pend_r <= (rd_acc & a_rtd ? 8'h00 : rtd_pend_r) |
                    ((rtd_f ^ rtd_prev_r) & ~mask_r);
      tx_pend_r  <= (tx_pend_r & ~(rd_acc & a_stat)) |
                    (frame_r & ctrl_r[phc_pkg::CB_TXINT_ARM]);
      ctl_new_r  <= (ctl_new_r & ~(rd_acc & a_stat)) | wbyte;
      if (wbyte)
        ctl_rx_r <= ish_nxt;
    end
  end

  // Interrupt driver and detector mux select
  wire irq = |rtd_pend_r | tx_pend_r | rtd_ev;
  always_ff @(posedge clk) begin
    if (rst_all) begin
      int_n               <= 1'b1;
      int_oe              <= 1'b1;
      detector_mux_select <= 1'b0;
      detector_mux_oe     <= 1'b0;
    end else begin
      int_n  <= ctrl_r[phc_pkg::CB_INT_OD] ? 1'b0 : ~irq;
      int_oe <= ctrl_r[phc_pkg::CB_INT_OD] ? irq : 1'b1;
      detector_mux_oe <= ctrl_r[phc_pkg::CB_MUX_EN];
      if (frame_r & ctrl_r[phc_pkg::CB_MUX_EN])
        detector_mux_select <= ~detector_mux_select;
    end
  end
endmodule // phc_core

// ### inc/phc_pkg.sv
// Package: register map, field positions, reset values and counts
package phc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SLOTS   = 8'h04;
  localparam logic [7:0] OFS_MASK    = 8'h08;
  localparam logic [7:0] OFS_RTD     = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CTLBYTE = 8'h14;
  localparam logic [7:0] OFS_TXDATA  = 8'h20;
  localparam logic [7:0] OFS_RXDATA  = 8'h30;
  // ==========================================================
  // Control register fields
  localparam int CB_LINEAR    = 0;
  localparam int CB_TX_A_EN   = 1;
  localparam int CB_TX_B_EN   = 2;
  localparam int CB_RX_FROM_B = 3;
  localparam int CB_CUTOFF    = 4;
  localparam int CB_ACTIVE    = 5;
  localparam int CB_SIGNAL    = 6;
  localparam int CB_INT_OD    = 7;
  localparam int CB_TXINT_ARM = 8;
  localparam int CB_MUX_EN    = 9;
  localparam int CB_CSLOT_LO  = 10;
  localparam int CTRL_W       = 13;
  // ==========================================================
  // Reset values
  localparam logic [12:0] CTRL_RST  = 13'h0000;
  localparam logic [31:0] SLOTS_RST = 32'h0302_0100;
  localparam logic [7:0]  MASK_RST  = 8'hFF;
  localparam logic [15:0] SYNC_RST  = 16'h00A0;  // Idle pins: chip select and reset pin high
  // ==========================================================
  // Counts
  localparam logic [4:0] CS_RST_EDGES = 5'h10;
  localparam int         SYNC_W       = 16;
  localparam int         POS_W        = 10;
endpackage

// ### verification/pcm_highway_control_pins_tb_top.sv
// Self-checking bench for the highway, control port and interrupt block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module pcm_highway_control_pins_tb_top;
  typedef struct packed {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} phc_row_t;
  // ==========================================================
  // Pins and bench state
  logic        clk, rst, read, write, waitrequest;
  logic [7:0]  address, rtd_in, got;
  logic [31:0] writedata, readdata, q;
  logic        pcm_clk, frame_sync, pcm_rx_a, pcm_rx_b, pcm_tx_a, pcm_tx_a_oe, pcm_tx_b, pcm_tx_b_oe;
  logic        slot_active_a_n, slot_active_a_oe, slot_active_b_n, slot_active_b_oe;
  logic        ctl_shift_clock, ctl_cs_n, serial_ctl_data_in, serial_ctl_data_out, serial_ctl_data_oe;
  logic        reset_pin_n, int_n, int_oe, detector_mux_select, detector_mux_oe;
  logic [15:0] oev;
  int          mismatches = 0;
  int          total_checks = 0;
  phc_row_t    rows [8] = '{
    '{phc_pkg::OFS_CTRL, 1'b0, 32'h0000_0000, {19'h0_0000, phc_pkg::CTRL_RST}},
    '{phc_pkg::OFS_SLOTS, 1'b0, 32'h0000_0000, phc_pkg::SLOTS_RST},
    '{phc_pkg::OFS_MASK, 1'b0, 32'h0000_0000, {24'h00_0000, phc_pkg::MASK_RST}},
    '{8'h40, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000},
    '{phc_pkg::OFS_CTRL, 1'b1, 32'hFFFF_FFFF, 32'h0000_1FFF},
    '{phc_pkg::OFS_SLOTS, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
    '{phc_pkg::OFS_SLOTS, 1'b1, 32'h0604_0200, 32'h0604_0200},
    '{phc_pkg::OFS_TXDATA, 1'b1, 32'hFFFF_A5C3, 32'h0000_A5C3}};
  phc_core dut (.*);
  phc_pcm_switch sw (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Bus, highway and control port helpers
  task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    address <= a;
    write <= wr_en;
    read <= !wr_en;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, q);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000, q);
    `CHK(nm, e, q & m)
  endtask
  task automatic frames(input int n);
    repeat (n) do @(posedge pcm_clk); while (frame_sync !== 1'b1);
  endtask
  task automatic txf(input logic [12:0] c, input logic [15:0] ea, input logic [15:0] ed, input logic [15:0] eb);
    logic [15:0] oa, da, ob, db;
    wr(phc_pkg::OFS_CTRL, {19'h0_0000, c});
    frames(2);
    for (int i = 15; i >= 0; i--) begin
      @(negedge pcm_clk);
      oa[i] = pcm_tx_a_oe;
      da[i] = pcm_tx_a;
      ob[i] = pcm_tx_b_oe;
      db[i] = pcm_tx_b;
    end
    `CHK("tx a enable", ea, oa)
    `CHK("tx a data", ed & ea, da & ea)
    `CHK("tx b enable", eb, ob)
    `CHK("tx b data", ed & eb, db & eb)
  endtask
  task automatic rxf(input logic [12:0] c, input logic [31:0] m, input logic [31:0] e);
    wr(phc_pkg::OFS_CTRL, {19'h0_0000, c});
    frames(3);
    rchk("rx word", phc_pkg::OFS_RXDATA, m, e);
  endtask
  task automatic ser(input logic [7:0] cmd, input int n);
    ctl_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_ctl_data_in <= (i < 8) ? cmd[7 - (i % 8)] : 1'b0;
      repeat (30) @(posedge clk);
      oev = {oev[14:0], serial_ctl_data_oe};
      got = {got[6:0], serial_ctl_data_out};
      ctl_shift_clock <= 1'b1;
      repeat (30) @(posedge clk);
      ctl_shift_clock <= 1'b0;
    end
    repeat (30) @(posedge clk);
    ctl_cs_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, ctl_cs_n, reset_pin_n} = 3'b111;
    {read, write, ctl_shift_clock, serial_ctl_data_in} = 4'h0;
    {address, rtd_in, writedata} = 48'h0000_0000_0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].wr) wr(rows[k].a, rows[k].d);
      rchk("register", rows[k].a, 32'hFFFF_FFFF, rows[k].e);
    end
    txf(13'h0022, 16'hFF00, 16'hC300, 16'h0000);
    txf(13'h0422, 16'h7F80, 16'h6180, 16'h0000);
    txf(13'h0023, 16'hFFFF, 16'hA5C3, 16'h0000);
    txf(13'h0026, 16'hFF00, 16'hC300, 16'hFF00);
    txf(13'h0032, 16'h0000, 16'h0000, 16'h0000);
    txf(13'h0002, 16'h0000, 16'h0000, 16'h0000);
    rxf(13'h0020, 32'h0000_00FF, 32'h0000_00C3);
    rxf(13'h0021, 32'h0000_FFFF, 32'h0000_C35A);
    rxf(13'h0028, 32'h0000_00FF, 32'h0000_003C);
    // Real-time input interrupt, mask, hold, clear and open drain
    wr(phc_pkg::OFS_CTRL, 32'h0000_0000);
    bus(phc_pkg::OFS_RTD, 1'b0, 32'h0000_0000, q);
    bus(phc_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, q);
    wr(phc_pkg::OFS_MASK, 32'h0000_00FE);
    rtd_in <= 8'h02;
    repeat (10) @(posedge clk);
    `CHK("masked input", 1'b1, int_n)
    rtd_in <= 8'h03;
    repeat (30) @(posedge clk);
    `CHK("input interrupt", 1'b0, int_n)
    rchk("rtd", phc_pkg::OFS_RTD, 32'h0000_00FF, 32'h0000_0003);
    repeat (10) @(posedge clk);
    `CHK("read clear", 1'b1, int_n)
    wr(phc_pkg::OFS_CTRL, 32'h0000_0080);
    rtd_in <= 8'h02;
    repeat (10) @(posedge clk);
    `CHK("open drain low", 2'b10, {int_oe, int_n})
    bus(phc_pkg::OFS_RTD, 1'b0, 32'h0000_0000, q);
    repeat (10) @(posedge clk);
    `CHK("open drain off", 2'b00, {int_oe, int_n})
    wr(phc_pkg::OFS_CTRL, 32'h0000_0100);
    frames(1);
    repeat (10) @(posedge clk);
    `CHK("tx interrupt", 1'b0, int_n)
    wr(phc_pkg::OFS_CTRL, 32'h0000_0000);
    bus(phc_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, q);
    repeat (10) @(posedge clk);
    `CHK("status clear", 1'b1, int_n)
    // Reset pin, serial read, chip-select reset
    wr(phc_pkg::OFS_CTRL, 32'h0000_0022);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    rchk("pin reset ctrl", phc_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("pin reset mask", phc_pkg::OFS_MASK, 32'hFFFF_FFFF, 32'h0000_00FF);
    wr(phc_pkg::OFS_CTLBYTE, 32'h0000_005A);
    ser(8'h80, 16);
    `CHK("serial read", 8'h5A, got)
    `CHK("serial drive", 16'h00FF, oev)
    wr(phc_pkg::OFS_CTRL, 32'h0000_0200);
    repeat (5) @(posedge clk);
    `CHK("mux enable", 1'b1, detector_mux_oe)
    frames(1);
    repeat (10) @(posedge clk);
    got[0] = detector_mux_select;
    frames(1);
    repeat (10) @(posedge clk);
    `CHK("mux toggle", ~got[0], detector_mux_select)
    ser(8'h00, 20);
    rchk("cs reset", phc_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    stop_test();
  end
endmodule // pcm_highway_control_pins_tb_top

// ### verification/phc_core_props.sv
// Concurrent checks on bus, highway, control port and interrupt pins
`timescale 1ns/100ps
module phc_core_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // Highway drive
  input wire logic        pcm_tx_a_oe,
  input wire logic        pcm_tx_b_oe,
  input wire logic        slot_active_a_n,
  input wire logic        slot_active_a_oe,
  input wire logic        slot_active_b_n,
  input wire logic        slot_active_b_oe,
  // Control port, reset pin, interrupt
  input wire logic        ctl_cs_n,
  input wire logic        serial_ctl_data_oe,
  input wire logic        reset_pin_n,
  input wire logic        int_n,
  input wire logic        int_oe
);
  // ==========================================================
  // Cutoff bit as last written, dropped on bus reset, reset pin low or chip select low
  logic cut_r;
  logic cut_nxt;
  wire  ctrl_wr = write && !waitrequest && (address == phc_pkg::OFS_CTRL);
  wire  irq_on  = int_oe && !int_n;
  assign cut_nxt = (!reset_pin_n || !ctl_cs_n) ? 1'b0 : (ctrl_wr ? writedata[phc_pkg::CB_CUTOFF] : cut_r);
  always_ff @(posedge clk) begin
    cut_r <= rst ? 1'b0 : cut_nxt;
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  chk_bus_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_reset_quiet: assert property ($past(rst) |-> waitrequest && int_n && int_oe && !pcm_tx_a_oe && !pcm_tx_b_oe)
    else $error("outputs not idle after reset");
  chk_slot_a_match: assert property (slot_active_a_oe == pcm_tx_a_oe && !(slot_active_a_oe && slot_active_a_n))
    else $error("slot active A differs from highway A drive");
  chk_slot_b_match: assert property (slot_active_b_oe == pcm_tx_b_oe && !(slot_active_b_oe && slot_active_b_n))
    else $error("slot active B differs from highway B drive");
  chk_cutoff_quiet: assert property (cut_r [*4] |-> !pcm_tx_a_oe && !pcm_tx_b_oe)
    else $error("highway driven while cut off");
  chk_ctl_float: assert property (ctl_cs_n [*8] |-> !serial_ctl_data_oe)
    else $error("control data driven while deselected");
  chk_int_hold: assert property (irq_on && reset_pin_n && ctl_cs_n && $past(ctl_cs_n, 8) && !read
    && !$past(read) && !$past(read, 2) |=> irq_on)
    else $error("interrupt dropped without read or reset");
endmodule // phc_core_props
bind phc_core phc_core_props u_props (.*);

// ### verification/phc_pcm_switch.sv
// PCM switch model: highway clock, frame sync and receive data
`timescale 1ns/100ps
module phc_pcm_switch #(
  parameter int          HALF  = 20,
  parameter int          FRAME = 64,
  parameter logic [15:0] PAT   = 16'hC35A
) (
  // System clock
  input  wire logic clk,
  // Highway pins
  output logic      pcm_clk,
  output logic      frame_sync,
  output logic      pcm_rx_a,
  output logic      pcm_rx_b
);
  int   cnt = 0;
  int   pos = 0;
  int   nxt;
  logic bit_v;
  // Next bit position and the receive bit sent in it
  assign nxt   = frame_sync ? 0 : pos + 1;
  assign bit_v = (nxt < 16) ? PAT[15 - (nxt % 16)] : nxt[0];
  initial begin
    pcm_clk    = 1'b0;
    frame_sync = 1'b0;
    pcm_rx_a   = 1'b0;
    pcm_rx_b   = 1'b1;
  end
  // Divided clock, whole bits per frame; sync moves on fall, data on rise
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      pcm_clk <= ~pcm_clk;
      if (pcm_clk) begin
        frame_sync <= (pos == FRAME - 1);
      end else begin
        pos      <= nxt;
        pcm_rx_a <= bit_v; // MSB first
        pcm_rx_b <= ~bit_v;
      end
    end
  end
endmodule // phc_pcm_switch
